// file: dv/cbci_exec_tb.sv
// Self-checking bench for the branch, call and indirect store executor
`timescale 1ns/1ps
`include "cbci_params.svh"

module cbci_exec_tb;
    import cbci_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic         clk, rst_n, start, carry, bit_value, busy, done, illegal;
    logic [7:0]   acc, ptr_reg0, ptr_reg1, stack_pointer;
    logic [15:0]  program_counter;
    cbci_insn_s   insn;
    cbci_mem_wr_s mem_wr;
    cbci_mem_wr_s wr_q[$];      // Writes seen during the last instruction
    logic [15:0]  exp_pc;       // Program counter the bench expects
    int           error_cnt, checks_done, cyc;

    cbci_exec i_dut (.clk(clk), .rst_n(rst_n), .start(start), .insn(insn), .acc(acc),
        .carry(carry), .bit_value(bit_value), .ptr_reg0(ptr_reg0), .ptr_reg1(ptr_reg1),
        .busy(busy), .done(done), .illegal(illegal), .program_counter(program_counter),
        .stack_pointer(stack_pointer), .mem_wr(mem_wr));

    // Clock at 50 ns period
    always #25 clk = ~clk;

    // ****************************************************************
    // Checking and reporting
    // ****************************************************************
    task automatic chk_val(input string what, input logic [16:0] exp, input logic [16:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_cnt(input string what, input int exp, input int got);
        checks_done++;
        if (got != exp) begin
            error_cnt++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // Hang guard: the whole run needs well under a hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            end_sim();
        end
    end

    // Issue one instruction, wait for done, collect writes and latency
    task automatic run(input cbci_insn_s i, input int lat, input logic ill);
        int n;
        wr_q.delete();
        @(negedge clk);
        insn = i;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        n = 1;
        // Busy only stands in the second cycle of a two-cycle instruction
        chk_val("busy", 17'(lat == 2), 17'(busy));
        while (done !== 1'b1 && n < 6) begin
            if (mem_wr.we === 1'b1) wr_q.push_back(mem_wr);
            @(negedge clk);
            n++;
        end
        if (mem_wr.we === 1'b1) wr_q.push_back(mem_wr);
        chk_cnt("latency", lat, n);
        chk_val("illegal", 17'(ill), 17'(illegal));
    endtask : run

    // Relative jump: pc advances by length, then adds the signed offset when taken
    task automatic jmp(input logic [7:0] op, b2, b3, input logic [15:0] len, input logic tk);
        logic [7:0] off;
        off = (len == `CBCI_LEN3) ? b3 : b2;
        exp_pc = exp_pc + len + (tk ? {{8{off[7]}}, off} : 16'h0000);
        run({op, b2, b3}, 2, 1'b0);
        chk_val("pc", 17'(exp_pc), 17'(program_counter));
        chk_cnt("jump writes", 0, wr_q.size());
    endtask : jmp

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_jumps();
        bit_value = 1'b0;
        jmp(`CBCI_OP_BIT_CLR, 8'h21, 8'hFC, `CBCI_LEN3, 1'b1);
        bit_value = 1'b1;
        jmp(`CBCI_OP_BIT_CLR, 8'h21, 8'h10, `CBCI_LEN3, 1'b0);
        carry = 1'b0;
        jmp(`CBCI_OP_CARRY_CLR, 8'h7F, 8'h00, `CBCI_LEN2, 1'b1);
        carry = 1'b1;
        jmp(`CBCI_OP_CARRY_CLR, 8'h7F, 8'h00, `CBCI_LEN2, 1'b0);
        acc = 8'h01;
        jmp(`CBCI_OP_ACC_NZ, 8'h80, 8'h00, `CBCI_LEN2, 1'b1);
        acc = 8'h00;
        jmp(`CBCI_OP_ACC_NZ, 8'h80, 8'h00, `CBCI_LEN2, 1'b0);
        jmp(`CBCI_OP_ACC_Z, 8'h05, 8'h00, `CBCI_LEN2, 1'b1);
        acc = 8'hFF;
        jmp(`CBCI_OP_ACC_Z, 8'h05, 8'h00, `CBCI_LEN2, 1'b0);
        $display("test jumps finished, mismatches %0d", error_cnt);
    endtask : t_jumps

    // Long call to the top of the space, then a jump that wraps past FFFF
    task automatic t_call();
        logic [15:0] ret;
        ret = exp_pc + `CBCI_LEN3;
        run({`CBCI_OP_LONG_CALL, 8'hFF, 8'hF0}, 2, 1'b0);
        chk_val("call pc", 17'h0FFF0, 17'(program_counter));
        chk_cnt("call writes", 2, wr_q.size());
        chk_val("push low", {1'b1, 8'h08, ret[7:0]}, wr_q[0]);
        chk_val("push high", {1'b1, 8'h09, ret[15:8]}, wr_q[1]);
        chk_val("sp", 17'h00009, 17'(stack_pointer));
        exp_pc = 16'hFFF0;
        acc = 8'h00;
        jmp(`CBCI_OP_ACC_Z, 8'h20, 8'h00, `CBCI_LEN2, 1'b1);
        $display("test call finished, mismatches %0d", error_cnt);
    endtask : t_call

    // Indirect stores through both pointer registers
    task automatic t_stores();
        logic [7:0] p;
        ptr_reg0 = 8'h6C;
        ptr_reg1 = 8'h6A;
        acc = 8'h55;
        for (int r = 0; r < 2; r++) begin
            p = r ? ptr_reg1 : ptr_reg0;
            run({`CBCI_OP_STI | 8'(r), 8'hAA, 8'h00}, 1, 1'b0);
            exp_pc = exp_pc + `CBCI_LEN2;
            chk_cnt("imm writes", 1, wr_q.size());
            chk_val("imm write", {1'b1, p, 8'hAA}, wr_q[0]);
            chk_val("imm pc", 17'(exp_pc), 17'(program_counter));
            run({`CBCI_OP_STA | 8'(r), 8'h00, 8'h00}, 1, 1'b0);
            exp_pc = exp_pc + 16'h0001;
            chk_cnt("acc writes", 1, wr_q.size());
            chk_val("acc write", {1'b1, p, 8'h55}, wr_q[0]);
            chk_val("acc pc", 17'(exp_pc), 17'(program_counter));
        end
        // An unhandled opcode must leave all state alone
        run({8'hA5, 8'h00, 8'h00}, 1, 1'b1);
        chk_cnt("bad writes", 0, wr_q.size());
        chk_val("bad pc", 17'(exp_pc), 17'(program_counter));
        chk_val("bad sp", 17'h00009, 17'(stack_pointer));
        $display("test stores finished, mismatches %0d", error_cnt);
    endtask : t_stores

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        start = 1'b0;
        insn = '0;
        {acc, carry, bit_value, ptr_reg0, ptr_reg1} = '0;
        error_cnt = 0;
        checks_done = 0;
        cyc = 0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        exp_pc = `CBCI_PC_RST;
        chk_val("reset pc", 17'(`CBCI_PC_RST), 17'(program_counter));
        chk_val("reset sp", 17'(`CBCI_SP_RST), 17'(stack_pointer));
        chk_val("reset strobes", 17'h00000, 17'({done, illegal, mem_wr.we, busy}));
        t_jumps();
        t_call();
        t_stores();
        end_sim();
    end

endmodule : cbci_exec_tb

// file: rtl/cbci_exec.sv
// Executor for conditional branches, long call and indirect stores
//
// What this block does
// - Bit-clear jump: pc+3, branch if bit 0
// - Carry-clear jump: branch when carry is 0
// - Acc-nonzero jump: pc+2, branch if nonzero
// - Acc-nonzero jump falls through when acc zero
// - Acc-zero jump: pc+2, branch if zero
// - Acc-zero jump falls through when nonzero
// - Long call reaches whole 64K space
// - Long call: byte2 high, byte3 low target
// - Immediate stored at pointer register address
// - Immediate store uses register 0/1, one cycle
// - Immediate store opcode 0111011r
// - Accumulator stored at pointer, register unchanged
// - Accumulator store opcode 1111011r, one cycle
`timescale 1ns/1ps
`include "cbci_params.svh"

module cbci_exec
    import cbci_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Instruction issue
    input  wire logic         start,
    input  wire cbci_insn_s   insn,
    // Core state read by the instructions
    input  wire logic [7:0]   acc,
    input  wire logic         carry,
    input  wire logic         bit_value,
    input  wire logic [7:0]   ptr_reg0,
    input  wire logic [7:0]   ptr_reg1,
    // Results
    output logic              busy,
    output logic              done,
    output logic              illegal,
    output logic [15:0]       program_counter,
    output logic [7:0]        stack_pointer,
    output cbci_mem_wr_s      mem_wr
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic              is_bit_clr;   // Jump if bit clear
    logic              is_carry_clr; // Jump if carry clear
    logic              is_acc_nz;    // Jump if accumulator nonzero
    logic              is_acc_z;     // Jump if accumulator zero
    logic              is_call;      // Long call
    logic              is_sti;       // Store immediate indirect
    logic              is_sta;       // Store accumulator indirect
    logic [7:0]        ptr_sel;      // Selected pointer register value
    logic              take;         // Branch condition met
    logic [15:0]       pc_adv;       // Program counter after advance
    logic [15:0]       disp;         // Sign-extended displacement
    logic [7:0]        disp_byte;    // Raw displacement byte
    logic [15:0]       ret_ff;       // Return address kept for high push
    logic [15:0]       tgt_ff;       // Call target kept for final load
    cbci_state_e       state_ff;     // Execution phase
    logic              issue;        // Start accepted this cycle
    logic              iss_jump;     // Accepted relative jump
    logic              iss_call;     // Accepted long call
    logic              iss_store;    // Accepted indirect store
    logic              iss_bad;      // Accepted code that is not handled

    assign is_bit_clr   = insn.op == `CBCI_OP_BIT_CLR;
    assign is_carry_clr = insn.op == `CBCI_OP_CARRY_CLR;
    assign is_acc_nz    = insn.op == `CBCI_OP_ACC_NZ;
    assign is_acc_z     = insn.op == `CBCI_OP_ACC_Z;
    assign is_call      = insn.op == `CBCI_OP_LONG_CALL;
    // Low opcode bit picks the pointer; only two encodings exist
    assign is_sti = (insn.op & `CBCI_OP_STI_MASK) == `CBCI_OP_STI;
    assign is_sta = (insn.op & `CBCI_OP_STI_MASK) == `CBCI_OP_STA;
    assign ptr_sel = insn.op[0] ? ptr_reg1 : ptr_reg0;

    // Advance length: three bytes for bit jump and call, else two
    always_comb begin
        if (is_bit_clr || is_call) begin
            pc_adv = program_counter + `CBCI_LEN3;
        end else begin
            pc_adv = program_counter + `CBCI_LEN2;
        end
    end

    // Bit jump carries its offset in byte 3, the others in byte 2
    assign disp_byte = is_bit_clr ? insn.b3 : insn.b2;
    assign disp = {{8{disp_byte[7]}}, disp_byte};

    // Branch conditions
    always_comb begin
        take = 1'b0;
        if (is_bit_clr) begin
            take = ~bit_value;
        end else if (is_carry_clr) begin
            take = ~carry;
        end else if (is_acc_nz) begin
            take = acc != 8'h00;
        end else if (is_acc_z) begin
            take = acc == 8'h00;
        end
    end

    assign busy = state_ff != CBCI_IDLE;

    // ****************************************************************
    // Sequencer, program counter and stack
    // ****************************************************************
    // Start counts only while idle; a start in a second cycle is dropped
    assign issue     = start && (state_ff == CBCI_IDLE);
    assign iss_jump  = issue && (is_bit_clr || is_carry_clr || is_acc_nz || is_acc_z);
    assign iss_call  = issue && is_call;
    assign iss_store = issue && (is_sti || is_sta);
    // Anything else is reported and otherwise leaves state alone
    assign iss_bad   = issue && !(is_bit_clr || is_carry_clr || is_acc_nz || is_acc_z
                                  || is_call || is_sti || is_sta);

    // Phase register: jumps and calls own a second cycle, stores do not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= CBCI_IDLE;
        end else begin
            case (state_ff)
                CBCI_IDLE: begin
                    if (iss_jump) begin
                        state_ff <= CBCI_DONE;
                    end else if (iss_call) begin
                        state_ff <= CBCI_PUSH_HI;
                    end
                end
                CBCI_PUSH_HI: begin
                    // High return byte is registered here and shows on the port in the next cycle
                    state_ff <= CBCI_IDLE;
                end
                CBCI_DONE: begin
                    // Second cycle of a two-cycle jump
                    state_ff <= CBCI_IDLE;
                end
                default: begin
                    // Unused code: fall back to idle rather than hang
                    state_ff <= CBCI_IDLE;
                end
            endcase
        end
    end

    // Program counter: jumps and stores move it at issue, a call at its end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_counter <= `CBCI_PC_RST;
        end else if (iss_jump) begin
            // Offset applies to the advanced address
            program_counter <= take ? pc_adv + disp : pc_adv;
        end else if (iss_store) begin
            // Immediate form is two bytes long, accumulator form one
            program_counter <= is_sti ? program_counter + `CBCI_LEN2
                                      : program_counter + `CBCI_LEN1;
        end else if (state_ff == CBCI_PUSH_HI) begin
            program_counter <= tgt_ff;
        end
    end

    // Stack pointer: one step before each pushed return byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer <= `CBCI_SP_RST;
        end else if (iss_call || (state_ff == CBCI_PUSH_HI)) begin
            stack_pointer <= stack_pointer + `CBCI_SP_STEP;
        end
    end

    // Call operands held over for the second cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ret_ff <= 16'h0000;
            tgt_ff <= 16'h0000;
        end else if (iss_call) begin
            ret_ff <= pc_adv;
            tgt_ff <= {insn.b2, insn.b3};
        end
    end

    // Data memory port: pushes and indirect stores, one-cycle strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr <= '0;
        end else if (iss_call) begin
            // Low return byte first, at the incremented pointer
            mem_wr.we   <= 1'b1;
            mem_wr.addr <= stack_pointer + `CBCI_SP_STEP;
            mem_wr.data <= pc_adv[7:0];
        end else if (state_ff == CBCI_PUSH_HI) begin
            mem_wr.we   <= 1'b1;
            mem_wr.addr <= stack_pointer + `CBCI_SP_STEP;
            mem_wr.data <= ret_ff[15:8];
        end else if (iss_store) begin
            // Pointer register itself is never written
            mem_wr.we   <= 1'b1;
            mem_wr.addr <= ptr_sel;
            mem_wr.data <= is_sti ? insn.b2 : acc;
        end else begin
            mem_wr <= '0;
        end
    end

    // Completion strobes: one cycle for stores and unknown codes, two otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done    <= 1'b0;
            illegal <= 1'b0;
        end else begin
            done    <= iss_store || iss_bad
                       || (state_ff == CBCI_PUSH_HI) || (state_ff == CBCI_DONE);
            illegal <= iss_bad;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence call_issue_s;
        !busy && start && is_call;
    endsequence

    sequence call_push_s;
        mem_wr.we ##1 mem_wr.we && done;
    endsequence

    // First push: low byte of the next instruction's address at sp+1
    sequence call_low_s;
        mem_wr.we && mem_wr.addr == $past(stack_pointer) + `CBCI_SP_STEP
        && mem_wr.data == 8'($past(program_counter) + `CBCI_LEN3);
    endsequence

    // Second push: high byte of that address at sp+2
    sequence call_high_s;
        mem_wr.we && mem_wr.addr == $past(stack_pointer, 2) + 8'h02
        && mem_wr.data == 8'(($past(program_counter, 2) + `CBCI_LEN3) >> 8);
    endsequence

    jump_two_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && (is_bit_clr || is_acc_z || is_acc_nz || is_carry_clr)
        |=> busy ##1 done && !busy)
        else $error("Jump did not finish in two cycles");

    bit_jump_pc_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_bit_clr && bit_value
        |=> program_counter == $past(program_counter) + 16'h0003)
        else $error("Bit jump taken with bit set");

    carry_jump_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_carry_clr && !carry
        |=> program_counter == $past(program_counter) + `CBCI_LEN2
            + {{8{$past(insn.b2[7])}}, $past(insn.b2)})
        else $error("Carry clear jump not taken");

    nz_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_acc_nz && acc == 8'h00
        |=> program_counter == $past(program_counter) + 16'h0002)
        else $error("Nonzero jump taken on zero accumulator");

    z_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_acc_z && acc != 8'h00
        |=> program_counter == $past(program_counter) + 16'h0002)
        else $error("Zero jump taken on nonzero accumulator");

    call_stack_a: assert property (@(posedge clk) disable iff (!rst_n)
        call_issue_s |=> call_push_s)
        else $error("Call push sequence wrong");

    call_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        call_issue_s |=> ##1 program_counter == {$past(insn.b2, 2), $past(insn.b3, 2)}
        && stack_pointer == $past(stack_pointer, 2) + 8'h02)
        else $error("Call target or stack pointer wrong");

    store_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && (is_sti || is_sta)
        |=> mem_wr.we && done && mem_wr.addr == $past(ptr_sel))
        else $error("Indirect store address wrong");

    // Taken forms: advanced address plus the signed offset byte; carry_fall_a checks the untaken carry jump
    bit_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_bit_clr && !bit_value
        |=> program_counter == $past(program_counter) + `CBCI_LEN3
            + {{8{$past(insn.b3[7])}}, $past(insn.b3)})
        else $error("Bit jump not taken with bit clear");

    carry_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_carry_clr && carry
        |=> program_counter == $past(program_counter) + `CBCI_LEN2)
        else $error("Carry clear jump taken with carry set");

    nz_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_acc_nz && acc != 8'h00
        |=> program_counter == $past(program_counter) + `CBCI_LEN2
            + {{8{$past(insn.b2[7])}}, $past(insn.b2)})
        else $error("Nonzero jump not taken");

    z_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_acc_z && acc == 8'h00
        |=> program_counter == $past(program_counter) + `CBCI_LEN2
            + {{8{$past(insn.b2[7])}}, $past(insn.b2)})
        else $error("Zero jump not taken");

    // Return address lands low byte first, at the two next stack slots
    call_return_a: assert property (@(posedge clk) disable iff (!rst_n)
        call_issue_s |=> call_low_s ##1 call_high_s)
        else $error("Return address push wrong");

    imm_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_sti
        |=> done && !busy && mem_wr.data == $past(insn.b2)
            && program_counter == $past(program_counter) + `CBCI_LEN2)
        else $error("Immediate store data or length wrong");

    acc_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && is_sta
        |=> done && !busy && mem_wr.data == $past(acc)
            && program_counter == $past(program_counter) + `CBCI_LEN1)
        else $error("Accumulator store data or length wrong");

    ptr_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busy && start && (is_sti || is_sta)
        |=> mem_wr.addr == ($past(insn.op[0]) ? $past(ptr_reg1) : $past(ptr_reg0)))
        else $error("Pointer register selection wrong");
endmodule : cbci_exec

// file: rtl/cbci_params.svh
// Constants for the conditional branch, long call and indirect store executor
`ifndef CBCI_PARAMS_SVH
`define CBCI_PARAMS_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define CBCI_OP_BIT_CLR   8'h30
`define CBCI_OP_CARRY_CLR 8'h50
`define CBCI_OP_ACC_NZ    8'h70
`define CBCI_OP_ACC_Z     8'h60
`define CBCI_OP_LONG_CALL     8'h12
`define CBCI_OP_STI_MASK  8'hFE
`define CBCI_OP_STI       8'h76
`define CBCI_OP_STA       8'hF6

// ****************************************************************
// Lengths and reset values
// ****************************************************************
`define CBCI_LEN2         16'h0002
`define CBCI_LEN3         16'h0003
`define CBCI_LEN1         16'h0001
`define CBCI_PC_RST       16'h0000
`define CBCI_SP_RST       8'h07
`define CBCI_SP_STEP      8'h01

`endif

// file: rtl/cbci_pkg.sv
// Types shared by the executor
package cbci_pkg;

    // Instruction bytes as fetched by the core
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b2;
        logic [7:0] b3;
    } cbci_insn_s;

    // Data memory write request
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } cbci_mem_wr_s;

    // Execution phases
    typedef enum logic [1:0] {
        CBCI_IDLE,
        CBCI_PUSH_HI,
        CBCI_DONE
    } cbci_state_e;

endpackage : cbci_pkg
